// ### rtl/isft_top.sv
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module isft_top
  import isft_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // register port
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // two-wire bus
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // interrupt
  output logic irq_o
);
  isft_sync_if ev();

  isft_edge u_edge (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .ev(ev)
  );

  logic [31:0] status;
  logic [31:0] mask;
  logic [31:0] ctrl;
  logic [7:0] tx_buffer_reg;
  logic [7:0] rx_buffer_reg;
  logic [7:0] rx_shift_reg;
  logic [7:0] tx_shift;
  logic [3:0] bit_cnt;
  isft_phase_t phase;
  logic busy;
  logic sda_drive;
  logic [31:0] next_status;
  logic [31:0] next_mask;
  logic [31:0] next_ctrl;
  logic [7:0] next_tx_buffer_reg;
  logic [7:0] next_rx_buffer_reg;
  logic [7:0] next_rx_shift_reg;
  logic [7:0] next_tx_shift;
  logic [3:0] next_bit_cnt;
  isft_phase_t next_phase;
  logic next_busy;
  logic next_sda_drive;
  logic [31:0] next_rdata;

  function automatic logic reg_hit(input logic [3:0] a, input logic [3:0] r);
    reg_hit = (a == r);
  endfunction

  logic is_master;
  logic byte_done;
  logic ack_end;
  logic [7:0] rx_byte;
  logic tx_wr;
  assign is_master = ctrl[CTL_MASTER];
  assign rx_byte = {rx_shift_reg[6:0], ev.sda};
  assign byte_done = ev.scl_rise && (bit_cnt == BITS_PER_BYTE - 4'h1);
  assign ack_end = ev.scl_fall && (bit_cnt == ACK_BIT);
  assign tx_wr = wr_i && reg_hit(addr_i, ADDR_TXBUF);

  always_comb begin
    next_status = status;
    next_mask = mask;
    next_ctrl = ctrl;
    next_tx_buffer_reg = tx_buffer_reg;
    next_rx_buffer_reg = rx_buffer_reg;
    next_rx_shift_reg = rx_shift_reg;
    next_tx_shift = tx_shift;
    next_bit_cnt = bit_cnt;
    next_phase = phase;
    next_busy = busy;
    next_sda_drive = sda_drive;
    next_rdata = 32'h0000_0000;

    // software side first so hardware sets below win over clears
    if (wr_i) begin
      if (reg_hit(addr_i, ADDR_STATUS)) begin
        next_status = status & ~(wdata_i & W1C_BITS);
      end
      if (reg_hit(addr_i, ADDR_MASK)) begin
        next_mask = wdata_i & W1C_BITS;
      end
      if (reg_hit(addr_i, ADDR_CTRL)) begin
        next_ctrl = wdata_i;
      end
    end
    if (rd_i) begin
      case (addr_i)
        ADDR_STATUS: next_rdata = status;
        ADDR_MASK: next_rdata = mask;
        ADDR_TXBUF: next_rdata = {24'h00_0000, tx_buffer_reg};
        ADDR_RXBUF: next_rdata = {24'h00_0000, rx_buffer_reg};
        ADDR_CTRL: next_rdata = ctrl;
        default: next_rdata = 32'h0000_0000;
      endcase
      if (reg_hit(addr_i, ADDR_RXBUF)) begin
        next_status[BIT_RBF] = 1'b0;
      end
    end

    if (tx_wr) begin
      if (busy || status[BIT_TBF]) begin
        next_status[BIT_WCOL] = 1'b1;
      end else begin
        next_tx_buffer_reg = wdata_i[7:0];
        next_status[BIT_TBF] = 1'b1;
      end
    end

    if (ev.start_seen) begin
      next_status[BIT_START] = 1'b1;
      next_status[BIT_STOP] = 1'b0;
      next_status[BIT_DA] = 1'b0;
      next_phase = ISFT_ADDR;
      // the start's own clock fall must not count as a bit
      next_bit_cnt = PRE_BIT;
      next_busy = 1'b1;
      next_sda_drive = 1'b0;
      if (is_master && status[BIT_TBF]) begin
        next_tx_shift = tx_buffer_reg;
        next_status[BIT_TBF] = 1'b0;
        next_status[BIT_TXACT] = 1'b1;
      end
    end else if (ev.stop_seen) begin
      next_status[BIT_STOP] = 1'b1;
      next_status[BIT_START] = 1'b0;
      next_status[BIT_GCALL] = 1'b0;
      next_status[BIT_TENB] = 1'b0;
      next_status[BIT_ACKWIN] = 1'b0;
      next_status[BIT_TXACT] = 1'b0;
      next_phase = ISFT_IDLE;
      next_busy = 1'b0;
      next_sda_drive = 1'b0;
    end else if (phase != ISFT_IDLE) begin
      if (ev.scl_rise && bit_cnt < BITS_PER_BYTE) begin
        next_rx_shift_reg = rx_byte;
        // line differs from the bit on the wire: arbitration lost, let go
        if (is_master && status[BIT_TXACT] && ev.sda == sda_drive) begin
          next_status[BIT_BCOL] = 1'b1;
          next_status[BIT_TXACT] = 1'b0;
          next_sda_drive = 1'b0;
        end
      end
      if (byte_done) begin
        if (phase == ISFT_ADDR) begin
          next_status[BIT_RW] = rx_byte[0];
          if (!is_master && ctrl[CTL_GCEN] && rx_byte[7:1] == GCALL_ADDR) begin
            next_status[BIT_GCALL] = 1'b1;
          end
          if (ctrl[CTL_TENBIT] && rx_byte[7:3] == TEN_PREFIX
              && rx_byte[2:1] == ctrl[25:24]) begin
            next_phase = ISFT_ADDR2;
          end else begin
            next_phase = ISFT_DATA;
          end
        end else if (phase == ISFT_ADDR2) begin
          if (!is_master && rx_byte == ctrl[23:16]) begin
            next_status[BIT_TENB] = 1'b1;
          end
          next_phase = ISFT_DATA;
        end else begin
          next_status[BIT_DA] = 1'b1;
          if (!is_master || !status[BIT_TXACT]) begin
            if (status[BIT_RBF]) begin
              next_status[BIT_OVF] = 1'b1;
            end else begin
              next_rx_buffer_reg = rx_byte;
              next_status[BIT_RBF] = 1'b1;
            end
          end
        end
      end
      if (ev.scl_fall) begin
        if (bit_cnt == BITS_PER_BYTE - 4'h1 && !is_master) begin
          next_status[BIT_ACKWIN] = 1'b1;
        end
        // a fall ahead of data bits one to eight puts the next bit out
        if (status[BIT_TXACT] && (bit_cnt < BITS_PER_BYTE - 4'h1 || bit_cnt == PRE_BIT)) begin
          next_sda_drive = ~tx_shift[7];
          next_tx_shift = {tx_shift[6:0], 1'b0};
        end else begin
          next_sda_drive = 1'b0;
        end
        next_bit_cnt = (bit_cnt >= ACK_BIT) ? 4'h0 : bit_cnt + 4'h1;
      end
      if (ev.scl_rise && bit_cnt == ACK_BIT) begin
        next_status[BIT_ACKWIN] = 1'b0;
        if (is_master && status[BIT_TXACT]) begin
          next_status[BIT_NACK] = ev.sda;
        end
      end
      if (ack_end && is_master) begin
        next_status[BIT_TXACT] = 1'b0;
        if (status[BIT_TBF] && !next_status[BIT_NACK]) begin
          // the acknowledge fall already leads the next byte's first bit
          next_sda_drive = ~tx_buffer_reg[7];
          next_tx_shift = {tx_buffer_reg[6:0], 1'b0};
          next_status[BIT_TBF] = 1'b0;
          next_status[BIT_TXACT] = 1'b1;
        end
      end
    end
    next_status[31:16] = 16'h0000;
    next_status[12:11] = 2'b00;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      status <= STATUS_RESET;
      mask <= MASK_RESET;
      ctrl <= CTRL_RESET;
      tx_buffer_reg <= 8'h00;
      rx_buffer_reg <= 8'h00;
      rx_shift_reg <= 8'h00;
      tx_shift <= 8'h00;
      bit_cnt <= 4'h0;
      phase <= ISFT_IDLE;
      busy <= 1'b0;
      sda_drive <= 1'b0;
      rdata_o <= 32'h0000_0000;
      irq_o <= 1'b0;
      sda_o <= 1'b0;
    end else begin
      status <= next_status;
      mask <= next_mask;
      ctrl <= next_ctrl;
      tx_buffer_reg <= next_tx_buffer_reg;
      rx_buffer_reg <= next_rx_buffer_reg;
      rx_shift_reg <= next_rx_shift_reg;
      tx_shift <= next_tx_shift;
      bit_cnt <= next_bit_cnt;
      phase <= next_phase;
      busy <= next_busy;
      sda_drive <= next_sda_drive;
      rdata_o <= next_rdata;
      irq_o <= |(next_status & next_mask & W1C_BITS);
      sda_o <= 1'b0;
    end
  end

  // open drain: data pin held low, only the enable moves
  assign sda_oe_o = sda_drive;
endmodule // isft_top
`default_nettype wire

// ### rtl/isft_pkg.sv
package isft_pkg;
  // register indices (byte address = index * 4)
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_MASK = 4'h1;
  localparam logic [3:0] ADDR_TXBUF = 4'h2;
  localparam logic [3:0] ADDR_RXBUF = 4'h3;
  localparam logic [3:0] ADDR_CTRL = 4'h4;
  // status bit positions
  localparam int BIT_NACK = 15;
  localparam int BIT_TXACT = 14;
  localparam int BIT_ACKWIN = 13;
  localparam int BIT_BCOL = 10;
  localparam int BIT_GCALL = 9;
  localparam int BIT_TENB = 8;
  localparam int BIT_WCOL = 7;
  localparam int BIT_OVF = 6;
  localparam int BIT_DA = 5;
  localparam int BIT_STOP = 4;
  localparam int BIT_START = 3;
  localparam int BIT_RW = 2;
  localparam int BIT_RBF = 1;
  localparam int BIT_TBF = 0;
  // ctrl bit positions
  localparam int CTL_MASTER = 0;
  localparam int CTL_TENBIT = 1;
  localparam int CTL_GCEN = 2;
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
  localparam logic [31:0] MASK_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [9:0] OWN_ADDR_RESET = 10'h000;
  // sticky bits that software clears by writing one
  localparam logic [31:0] W1C_BITS = 32'h0000_24d8;
  localparam logic [6:0] GCALL_ADDR = 7'h00;
  localparam logic [4:0] TEN_PREFIX = 5'h1e;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] ACK_BIT = 4'h8;
  // count parked here from a start until that start's own clock fall
  localparam logic [3:0] PRE_BIT = 4'h9;
  typedef enum logic [1:0] {
    ISFT_IDLE = 2'b00,
    ISFT_ADDR = 2'b01,
    ISFT_ADDR2 = 2'b10,
    ISFT_DATA = 2'b11
  } isft_phase_t;
endpackage

// ### rtl/isft_sync_if.sv
`timescale 1ns/1ps
`default_nettype none
interface isft_sync_if;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  modport edge_src (output scl, sda, scl_rise, scl_fall, start_seen, stop_seen);
  modport edge_dst (input scl, sda, scl_rise, scl_fall, start_seen, stop_seen);
endinterface
`default_nettype wire

// ### rtl/isft_edge.sv
`timescale 1ns/1ps
`default_nettype none
module isft_edge
  import isft_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  isft_sync_if.edge_src ev
);
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic scl_q;
  logic sda_q;
  logic [1:0] next_scl_sync;
  logic [1:0] next_sda_sync;
  always_comb begin
    next_scl_sync = {scl_sync[0], scl_i};
    next_sda_sync = {sda_sync[0], sda_i};
  end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      scl_sync <= 2'b11;
      sda_sync <= 2'b11;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_sync <= next_scl_sync;
      sda_sync <= next_sda_sync;
      scl_q <= scl_sync[1];
      sda_q <= sda_sync[1];
    end
  end
  // only the second stage and its registered copy are looked at, never the first stage
  assign ev.scl = scl_sync[1];
  assign ev.sda = sda_sync[1];
  assign ev.scl_rise = scl_sync[1] & ~scl_q;
  assign ev.scl_fall = ~scl_sync[1] & scl_q;
  assign ev.start_seen = scl_sync[1] & scl_q & sda_q & ~sda_sync[1];
  assign ev.stop_seen = scl_sync[1] & scl_q & ~sda_q & sda_sync[1];
endmodule // isft_edge
`default_nettype wire

// ### bench/isft_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module isft_bus_model (
  // bus drive, pull_o high pulls sda low
  output logic scl_o,
  output logic pull_o,
  // high through the acknowledge slot
  output logic ack_slot_o
);
  initial begin
    scl_o = 1'b1;
    pull_o = 1'b0;
    ack_slot_o = 1'b0;
  end
  // step off the clock edge the caller may have just used
  task automatic start();
    #1 pull_o = 1'b1;
    #40 scl_o = 1'b0;
  endtask
  // p[8] first on the wire, p[0] is the ack slot
  task automatic xfer(input logic [8:0] p);
    for (int i = 8; i >= 0; i--) begin
      ack_slot_o = (i == 0);
      // release after the fall, never while scl is high
      #10 pull_o = 1'b0;
      #30 pull_o = p[i];
      #20 scl_o = 1'b1;
      #20 scl_o = 1'b0;
    end
    ack_slot_o = 1'b0;
  endtask
  task automatic stop();
    #10 pull_o = 1'b1;
    #30 scl_o = 1'b1;
    #40 pull_o = 1'b0;
    #40;
  endtask
endmodule // isft_bus_model
`default_nettype wire

// ### bench/isft_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
module isft_top_chk
  import isft_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // register port
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  // two-wire bus and interrupt
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic irq_o
);
  localparam logic [31:0] CTRL_FIELDS = 32'h03ff_0007;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_rd_gap; !$past(rd_i) |-> rdata_o == 32'h0000_0000; endproperty
  a_rd_gap: assert property (p_rd_gap) else $error("read data outside its cycle");
  property p_sda_o; sda_o == 1'b0; endproperty
  a_sda_o: assert property (p_sda_o) else $error("sda data pin not low");
  property p_unmapped; rd_i && addr_i > ADDR_CTRL |=> rdata_o == 32'h0000_0000; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_upper;
    rd_i && addr_i == ADDR_STATUS |=> rdata_o[31:16] == 16'h0000 && rdata_o[12:11] == 2'b00;
  endproperty
  a_upper: assert property (p_upper) else $error("unused status bits set");
  property p_mask; rd_i && addr_i == ADDR_MASK |=> (rdata_o & ~W1C_BITS) == 32'h0000_0000; endproperty
  a_mask: assert property (p_mask) else $error("mask holds unused bits");
  property p_ctrl;
    wr_i && addr_i == ADDR_CTRL ##2 rd_i && addr_i == ADDR_CTRL
      |=> (rdata_o & CTRL_FIELDS) == ($past(wdata_i, 3) & CTRL_FIELDS);
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("control readback wrong");
  property p_bcol_clr;
    wr_i && addr_i == ADDR_STATUS && wdata_i[BIT_BCOL] ##2 rd_i && addr_i == ADDR_STATUS
      |=> !rdata_o[BIT_BCOL];
  endproperty
  a_bcol_clr: assert property (p_bcol_clr) else $error("collision flag not cleared");
  property p_wcol_clr;
    wr_i && addr_i == ADDR_STATUS && wdata_i[BIT_WCOL] ##2 rd_i && addr_i == ADDR_STATUS
      |=> !rdata_o[BIT_WCOL];
  endproperty
  a_wcol_clr: assert property (p_wcol_clr) else $error("write collision not cleared");
  property p_irq_off; wr_i && addr_i == ADDR_MASK && wdata_i == 32'h0000_0000 |-> ##[1:3] !irq_o;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("interrupt high with mask clear");
endmodule // isft_top_chk
bind isft_top isft_top_chk isft_top_chk_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .scl_i(scl_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe_o(sda_oe_o), .irq_o(irq_o));
`default_nettype wire

// ### bench/isft_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module isft_top_test;
  import isft_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [31:0] wdata_i = 32'h0000_0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rdata_o;
  logic [31:0] d;
  logic sda_o, sda_oe_o, irq_o, scl_w, pull, slot;
  wire logic sda_w;
  int fails = 0;
  int checked = 0;
  int k;
  always #5 clk_i = ~clk_i;
  // open-drain line with pull-up
  assign sda_w = !(sda_oe_o || pull);
  isft_bus_model isft_bus_model_i (.scl_o(scl_w), .pull_o(pull), .ack_slot_o(slot));
  isft_top isft_top_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .scl_i(scl_w), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .irq_o(irq_o));
  task complete_run;
    if (fails == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task rd(input logic [3:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task sb(input int b, input logic e);
    rd(ADDR_STATUS);
    chk({31'h0, d[b]}, {31'h0, e});
  endtask
  task t_regs;
    rd(ADDR_STATUS);
    chk(d, STATUS_RESET);
    rd(ADDR_MASK);
    chk(d, MASK_RESET);
    rd(4'hf);
    chk(d, 32'h0000_0000);
    wr(ADDR_CTRL, 32'h02b5_0002);
    rd(ADDR_CTRL);
    chk(d, 32'h02b5_0002);
  endtask
  task t_tenbit;
    isft_bus_model_i.start();
    isft_bus_model_i.xfer({~8'hf4, 1'b0});
    sb(BIT_TENB, 1'b0);
    sb(BIT_START, 1'b1);
    sb(BIT_RW, 1'b0);
    isft_bus_model_i.xfer({~8'hb5, 1'b0});
    sb(BIT_TENB, 1'b1);
    isft_bus_model_i.stop();
    sb(BIT_TENB, 1'b0);
    sb(BIT_STOP, 1'b1);
    sb(BIT_START, 1'b0);
  endtask
  task t_gcall;
    wr(ADDR_CTRL, 32'h0000_0004);
    isft_bus_model_i.start();
    fork
      isft_bus_model_i.xfer(9'h1fe);
      begin
        for (k = 0; k < 200 && slot !== 1'b1; k++) @(posedge clk_i);
        chk({31'h0, slot}, 32'h0000_0001);
        repeat (3) @(posedge clk_i);
        sb(BIT_ACKWIN, 1'b1);
      end
    join
    sb(BIT_ACKWIN, 1'b0);
    sb(BIT_GCALL, 1'b1);
    // drain whatever the address byte left behind
    rd(ADDR_RXBUF);
    isft_bus_model_i.xfer({~8'ha5, 1'b0});
    sb(BIT_RBF, 1'b1);
    sb(BIT_DA, 1'b1);
    isft_bus_model_i.xfer({~8'h3c, 1'b0});
    sb(BIT_OVF, 1'b1);
    rd(ADDR_RXBUF);
    chk(d & 32'h0000_00ff, 32'h0000_00a5);
    isft_bus_model_i.stop();
    sb(BIT_GCALL, 1'b0);
    wr(ADDR_STATUS, 32'h0000_0040);
    sb(BIT_OVF, 1'b0);
  endtask
  task t_master;
    wr(ADDR_CTRL, 32'h0000_0001);
    wr(ADDR_MASK, 32'h0000_0080);
    wr(ADDR_TXBUF, 32'h0000_00ff);
    sb(BIT_TBF, 1'b1);
    wr(ADDR_TXBUF, 32'h0000_0012);
    for (k = 0; k < 8 && irq_o !== 1'b1; k++) @(negedge clk_i);
    chk({31'h0, irq_o}, 32'h0000_0001);
    wr(ADDR_STATUS, 32'h0000_0080);
    sb(BIT_WCOL, 1'b0);
    wr(ADDR_MASK, 32'h0000_0000);
    isft_bus_model_i.start();
    sb(BIT_TXACT, 1'b1);
    isft_bus_model_i.xfer(9'h000);
    sb(BIT_NACK, 1'b1);
    sb(BIT_TXACT, 1'b0);
    sb(BIT_RW, 1'b1);
    isft_bus_model_i.stop();
    wr(ADDR_TXBUF, 32'h0000_0055);
    isft_bus_model_i.start();
    isft_bus_model_i.xfer(9'h001);
    sb(BIT_NACK, 1'b0);
    isft_bus_model_i.stop();
    sb(BIT_BCOL, 1'b0);
    wr(ADDR_TXBUF, 32'h0000_00ff);
    isft_bus_model_i.start();
    isft_bus_model_i.xfer(9'h100);
    isft_bus_model_i.stop();
    sb(BIT_BCOL, 1'b1);
    wr(ADDR_STATUS, 32'h0000_0400);
    sb(BIT_BCOL, 1'b0);
  endtask
  initial begin
    #500_000;
    fails++;
    complete_run();
  end
  initial begin
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_regs();
    t_tenbit();
    t_gcall();
    t_master();
    complete_run();
  end
endmodule // isft_top_test
`default_nettype wire
